// [logic/sasq_defines.svh]
// Overview of operation
// RULE1: Software never converts a digital pin nor drives an analog pin as output.
// RULE2: An analog input pin is digitised only when it is the selected channel.
// RULE3: Unselected analog pins stay analog and are never sampled.
// RULE4: Channel six is comparator common input when both mode-select bits are one.
// RULE5: Comparator enable decides whether channels three to five feed its positive input.
// RULE6: Channel eight's function comes from second pin config and port 7 direction.
// RULE7: Mode register bits 5 to 1 hold rate field and mode field.
// RULE8: Mode register bit 0 powers the comparator, apart from the start bit.
// RULE9: Writing one to mode bit 7 starts conversion; hardware sequences the rest. The code starts only while mode bit 0 is also one.
// RULE10: Software selects exactly one channel at a time.
// RULE11: Each conversion samples for a fixed period, then holds until done.
// RULE12: First trial sets bit 9; kept when comparator says input is at least trial.
// RULE13: Each next lower bit is trialled, kept when input is at least trial.
// RULE14: Trials continue down to and including bit 0.
// RULE15: After ten bits the value is latched into full, high and low results.
// RULE16: The conversion-end interrupt pulses when the result is latched.
// RULE17: Conversions repeat until software clears the start bit, which stops them.
// RULE18: Restart by setting start again; after comparator power-up wait one microsecond.
// RULE19: Software waits one microsecond between comparator enable and start.
// RULE20: To change channel, software rewrites selection then sets start again.
// RULE21: Software clears start before changing mode and channel.
// RULE22: Internal reference needs ten microseconds settling before start, while stopped.
// RULE23: Results read as 16-bit full, upper eight bits, and lower eight bits.
// RULE24: Reset clears all result registers to zero.
// RULE25: Writing channel selection mid-conversion aborts it; restarts if start set.
// RULE26: Comparator decision is one input sampled per trial; trial code is output.
// RULE27: Sample and trial durations are clock counts derived from the rate field.
`ifndef SASQ_DEFINES_SVH
`define SASQ_DEFINES_SVH
`define SASQ_OFF_MODE     12'h000
`define SASQ_OFF_CHSEL    12'h004
`define SASQ_OFF_RES_FULL 12'h008
`define SASQ_OFF_RES_HIGH 12'h00C
`define SASQ_OFF_RES_LOW  12'h010
`define SASQ_OFF_PINCFG0  12'h014
`define SASQ_OFF_PINCFG1  12'h018
`define SASQ_OFF_PDIR2    12'h01C
`define SASQ_OFF_PDIR7    12'h020
`define SASQ_OFF_CMPCTL0  12'h024
`define SASQ_OFF_CMPCTL1  12'h028
`define SASQ_OFF_CMPCTL2  12'h02C
`define SASQ_OFF_STATUS   12'h030
`define SASQ_MODE_START   7
`define SASQ_MODE_RATE_HI 5
`define SASQ_MODE_RATE_LO 3
`define SASQ_MODE_OPM_HI  2
`define SASQ_MODE_OPM_LO  1
`define SASQ_MODE_CMPEN   0
`define SASQ_MODE_VREF    6
`define SASQ_CMP_EN       7
`define SASQ_CMP_MSEL_HI  4
`define SASQ_CMP_MSEL_LO  3
`define SASQ_SAMPLE_BASE  8'h08
`define SASQ_TRIAL_BASE   8'h02
`define SASQ_RES_RESET    16'h0000
`define SASQ_BYTE_RESET   8'h00
`define SASQ_CH_COUNT     9
`define SASQ_SAR_MSB      9
`endif

// [logic/sasq_pkg.sv]
package sasq_pkg;
   typedef enum logic [1:0] {
      SASQ_IDLE,
      SASQ_SAMPLE,
      SASQ_TRIAL
   } sasq_state_e;
   typedef logic [9:0] sasq_code_t;
endpackage : sasq_pkg

// [logic/sasq_seq_if.sv]
`timescale 1ns/1ns
interface sasq_seq_if;
   logic              run;
   logic              abort;
   logic [2:0]        rate;
   logic              cmp_in;
   logic              sampling;
   logic              done;
   sasq_pkg::sasq_code_t code;
   modport ctrl (output run, output abort, output rate, output cmp_in,
                 input sampling, input done, input code);
   modport seq  (input run, input abort, input rate, input cmp_in,
                 output sampling, output done, output code);
endinterface : sasq_seq_if

// [logic/sasq_pin_map.sv]
`timescale 1ns/1ns
`include "sasq_defines.svh"
module sasq_pin_map (
   input  wire logic [7:0] pin_cfg0,
   input  wire logic [7:0] pin_cfg1,
   input  wire logic [7:0] dir2,
   input  wire logic [7:0] dir7,
   input  wire logic [3:0] chan,
   input  wire logic [7:0] cmp_ctl [3],
   output logic      [8:0] analog_en,
   output logic      [8:0] convert_en,
   output logic      [2:0] cmp_plus_en,
   output logic            cmp_common_en
);
   // Configuration bit set marks a pin analog; direction bit set marks input.
   genvar g;
   generate
      for (g = 0; g < `SASQ_CH_COUNT; g++) begin : g_pin
         if (g == 8) begin : g_p7
            assign analog_en[g] = pin_cfg1[0] & dir7[0]; // RULE6
         end else begin : g_p2
            assign analog_en[g] = pin_cfg0[g] & dir2[g];
         end
         assign convert_en[g] = analog_en[g] && (chan == 4'(g)); // RULE2 RULE3
      end
      for (g = 0; g < 3; g++) begin : g_cmp
         // Channels 3,4,5 feed comparators 2,0,1 respectively.
         assign cmp_plus_en[g] = cmp_ctl[g][`SASQ_CMP_EN] & analog_en[(g + 1) % 3 + 3]; // RULE5
      end
   endgenerate
   always_comb begin
      cmp_common_en = 1'b0;
      for (int m = 0; m < 3; m++) begin
         if (cmp_ctl[m][`SASQ_CMP_MSEL_HI] && cmp_ctl[m][`SASQ_CMP_MSEL_LO]) begin
            cmp_common_en = analog_en[6]; // RULE4
         end
      end
   end
endmodule : sasq_pin_map

// [logic/sasq_sar_core.sv]
`timescale 1ns/1ns
`include "sasq_defines.svh"
module sasq_sar_core (
   input  wire logic clk,
   input  wire logic sys_rst,
   sasq_seq_if.seq   bus
);
   sasq_pkg::sasq_state_e state_reg;
   sasq_pkg::sasq_code_t  sar_reg;
   logic [3:0]            bit_reg;
   logic [10:0]           cnt_reg;
   logic [10:0]           sample_len;
   logic [10:0]           trial_len;
   logic                  done_reg;
   // Slower rate codes stretch both phases; a longer trial eases comparator settling.
   assign sample_len = 11'(`SASQ_SAMPLE_BASE) << bus.rate; // RULE27
   assign trial_len  = 11'(`SASQ_TRIAL_BASE) << bus.rate; // RULE27
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= sasq_pkg::SASQ_IDLE;
         sar_reg   <= 10'h000;
         bit_reg   <= 4'h0;
         cnt_reg   <= 11'h000;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (!bus.run || bus.abort) begin
            state_reg <= sasq_pkg::SASQ_IDLE; // RULE17 RULE25
            cnt_reg   <= 11'h000;
         end else begin
            unique case (state_reg)
               sasq_pkg::SASQ_IDLE: begin
                  state_reg <= sasq_pkg::SASQ_SAMPLE; // RULE9
                  cnt_reg   <= 11'h000;
                  sar_reg   <= 10'h000;
               end
               sasq_pkg::SASQ_SAMPLE: begin
                  cnt_reg <= cnt_reg + 11'h001;
                  if (cnt_reg == sample_len - 11'h001) begin
                     state_reg <= sasq_pkg::SASQ_TRIAL; // RULE11
                     bit_reg   <= 4'(`SASQ_SAR_MSB);
                     sar_reg   <= 10'h200; // RULE12
                     cnt_reg   <= 11'h000;
                  end
               end
               sasq_pkg::SASQ_TRIAL: begin
                  cnt_reg <= cnt_reg + 11'h001;
                  if (cnt_reg == trial_len - 11'h001) begin
                     cnt_reg <= 11'h000;
                     // Equal input lands on the keep side of the decision.
                     if (!bus.cmp_in) begin
                        sar_reg[bit_reg] <= 1'b0; // RULE12 RULE13 RULE26
                     end
                     if (bit_reg == 4'h0) begin
                        done_reg  <= 1'b1; // RULE14 RULE15
                        state_reg <= sasq_pkg::SASQ_SAMPLE; // RULE17
                     end else begin
                        sar_reg[bit_reg - 4'h1] <= 1'b1; // RULE13
                        bit_reg <= bit_reg - 4'h1;
                     end
                  end
               end
            endcase
         end
      end
   end
   assign bus.sampling = (state_reg == sasq_pkg::SASQ_SAMPLE); // RULE11
   assign bus.done     = done_reg;
   assign bus.code     = sar_reg;
   a_trial_order: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
      (state_reg == sasq_pkg::SASQ_SAMPLE) ##1 (state_reg == sasq_pkg::SASQ_TRIAL)
      |-> sar_reg == 10'h200 && bit_reg == 4'h9)
      else $error("first trial does not set top bit");
endmodule : sasq_sar_core

// [logic/sasq_top.sv]
`timescale 1ns/1ns
`include "sasq_defines.svh"
module sasq_top (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmp_decision,
   output logic      [9:0]  trial_code,
   output logic             sample_hold_n,
   output logic             comparator_power,
   output logic             internal_ref_select,
   output logic             conversion_end_irq,
   output logic      [8:0]  analog_in_en,
   output logic      [8:0]  convert_sel,
   output logic      [2:0]  comparator_plus_en,
   output logic             comparator_common_input
);
   logic [7:0]  converter_mode_reg;
   logic [3:0]  channel_select_reg;
   logic [7:0]  analog_pin_config_0;
   logic [7:0]  analog_pin_config_1;
   logic [7:0]  port2_direction;
   logic [7:0]  port7_direction;
   logic [7:0]  comparator_control_reg [3];
   logic [15:0] conversion_result_full;
   logic [7:0]  conversion_result_high;
   logic [7:0]  conversion_result_low;
   logic        abort_reg;
   logic        cmp_meta_reg;
   logic        cmp_sync_reg;
   logic        wr_en;
   logic        rd_en;
   logic [8:0]  analog_en_w;
   logic [8:0]  convert_en_w;
   logic [2:0]  cmp_plus_w;
   logic        cmp_common_w;
   sasq_seq_if  seq_bus ();

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a <= `SASQ_OFF_STATUS) && (a[1:0] == 2'b00);
   endfunction : addr_known

   // Comparator output is analog-derived and asynchronous to clk.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
      end else begin
         cmp_meta_reg <= cmp_decision;
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         converter_mode_reg  <= 8'h00;
         channel_select_reg  <= 4'h0;
         analog_pin_config_0 <= 8'h00;
         analog_pin_config_1 <= 8'h00;
         port2_direction     <= 8'hFF;
         port7_direction     <= 8'hFF;
         comparator_control_reg <= '{8'h00, 8'h00, 8'h00};
         abort_reg           <= 1'b0;
      end else begin
         abort_reg <= 1'b0;
         if (wr_en) begin
            unique case (paddr)
               `SASQ_OFF_MODE:    converter_mode_reg <= pwdata[7:0]; // RULE7 RULE8 RULE9
               `SASQ_OFF_CHSEL: begin
                  channel_select_reg <= pwdata[3:0];
                  abort_reg          <= 1'b1; // RULE25
               end
               `SASQ_OFF_PINCFG0: analog_pin_config_0 <= pwdata[7:0];
               `SASQ_OFF_PINCFG1: analog_pin_config_1 <= pwdata[7:0]; // RULE6
               `SASQ_OFF_PDIR2:   port2_direction <= pwdata[7:0];
               `SASQ_OFF_PDIR7:   port7_direction <= pwdata[7:0]; // RULE6
               `SASQ_OFF_CMPCTL0: comparator_control_reg[0] <= pwdata[7:0];
               `SASQ_OFF_CMPCTL1: comparator_control_reg[1] <= pwdata[7:0];
               `SASQ_OFF_CMPCTL2: comparator_control_reg[2] <= pwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // Results load together so a reader never sees halves of two conversions.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conversion_result_full <= `SASQ_RES_RESET; // RULE24
         conversion_result_high <= `SASQ_BYTE_RESET; // RULE24
         conversion_result_low  <= `SASQ_BYTE_RESET; // RULE24
         conversion_end_irq     <= 1'b0;
      end else begin
         conversion_end_irq <= seq_bus.done; // RULE16
         if (seq_bus.done) begin
            conversion_result_full <= {6'h00, seq_bus.code}; // RULE15 RULE23
            conversion_result_high <= seq_bus.code[9:2]; // RULE23
            conversion_result_low  <= seq_bus.code[7:0]; // RULE23
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_known(paddr);
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `SASQ_OFF_MODE:     prdata <= {24'h000000, converter_mode_reg};
               `SASQ_OFF_CHSEL:    prdata <= {28'h0000000, channel_select_reg};
               `SASQ_OFF_RES_FULL: prdata <= {16'h0000, conversion_result_full};
               `SASQ_OFF_RES_HIGH: prdata <= {24'h000000, conversion_result_high};
               `SASQ_OFF_RES_LOW:  prdata <= {24'h000000, conversion_result_low};
               `SASQ_OFF_PINCFG0:  prdata <= {24'h000000, analog_pin_config_0};
               `SASQ_OFF_PINCFG1:  prdata <= {24'h000000, analog_pin_config_1};
               `SASQ_OFF_PDIR2:    prdata <= {24'h000000, port2_direction};
               `SASQ_OFF_PDIR7:    prdata <= {24'h000000, port7_direction};
               `SASQ_OFF_CMPCTL0:  prdata <= {24'h000000, comparator_control_reg[0]};
               `SASQ_OFF_CMPCTL1:  prdata <= {24'h000000, comparator_control_reg[1]};
               `SASQ_OFF_CMPCTL2:  prdata <= {24'h000000, comparator_control_reg[2]};
               `SASQ_OFF_STATUS:   prdata <= {30'h00000000, seq_bus.sampling,
                                              seq_bus.run};
               default: ;
            endcase
         end
      end
   end

   // A start with the comparator unpowered is held off; settling time is software's job.
   assign seq_bus.run    = converter_mode_reg[`SASQ_MODE_START]
                           && converter_mode_reg[`SASQ_MODE_CMPEN]; // RULE9 RULE17 RULE18
   assign seq_bus.abort  = abort_reg; // RULE25
   assign seq_bus.rate   = converter_mode_reg[`SASQ_MODE_RATE_HI:`SASQ_MODE_RATE_LO]; // RULE7
   assign seq_bus.cmp_in = cmp_sync_reg; // RULE26

   sasq_sar_core u_core (
      .clk     (clk),
      .sys_rst (sys_rst),
      .bus     (seq_bus)
   );

   sasq_pin_map u_pins (
      .pin_cfg0      (analog_pin_config_0),
      .pin_cfg1      (analog_pin_config_1),
      .dir2          (port2_direction),
      .dir7          (port7_direction),
      .chan          (channel_select_reg),
      .cmp_ctl       (comparator_control_reg),
      .analog_en     (analog_en_w),
      .convert_en    (convert_en_w),
      .cmp_plus_en   (cmp_plus_w),
      .cmp_common_en (cmp_common_w)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trial_code              <= 10'h000;
         sample_hold_n           <= 1'b0;
         comparator_power        <= 1'b0;
         internal_ref_select     <= 1'b0;
         analog_in_en            <= 9'h000;
         convert_sel             <= 9'h000;
         comparator_plus_en      <= 3'h0;
         comparator_common_input <= 1'b0;
      end else begin
         trial_code              <= seq_bus.code; // RULE26
         sample_hold_n           <= !seq_bus.sampling; // RULE11
         comparator_power        <= converter_mode_reg[`SASQ_MODE_CMPEN]; // RULE8
         internal_ref_select     <= converter_mode_reg[`SASQ_MODE_VREF];
         analog_in_en            <= analog_en_w; // RULE2 RULE3
         convert_sel             <= convert_en_w; // RULE2 RULE3
         comparator_plus_en      <= cmp_plus_w; // RULE5
         comparator_common_input <= cmp_common_w; // RULE4
      end
   end

   a_result_latch: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
      seq_bus.done |=> conversion_result_full[9:0] == $past(seq_bus.code)
         && conversion_end_irq)
      else $error("result not latched with interrupt");
   a_bytes_match: assert property (@(posedge clk) disable iff (sys_rst) // RULE23
      conversion_result_high == conversion_result_full[9:2]
         && conversion_result_low == conversion_result_full[7:0])
      else $error("result views disagree");
   a_stop_idle: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
      !seq_bus.run ##1 !seq_bus.run |-> !seq_bus.done && !seq_bus.sampling)
      else $error("converter active while stopped");
   sequence s_chsel_write;
      wr_en && paddr == `SASQ_OFF_CHSEL;
   endsequence : s_chsel_write
   sequence s_run_then_idle;
      seq_bus.run ##1 1'b1;
   endsequence : s_run_then_idle
   a_chsel_abort: assert property (@(posedge clk) disable iff (sys_rst) // RULE25
      s_chsel_write ##1 s_run_then_idle |=> seq_bus.sampling)
      else $error("channel write did not restart");
   a_irq_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
      conversion_end_irq |=> !conversion_end_irq)
      else $error("interrupt longer than a pulse");
   a_convert_one: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
      $onehot0(convert_sel) && ((convert_sel & ~analog_in_en) == 9'h000))
      else $error("non analog pin selected for conversion");
   a_power_follow: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
      wr_en && paddr == `SASQ_OFF_MODE |-> ##2 comparator_power == $past(pwdata[0], 2))
      else $error("comparator power not following mode bit");
endmodule : sasq_top

// [test/sasq_top_tb_top.sv]
`timescale 1ns/1ns
`include "sasq_defines.svh"
module sasq_top_tb_top;
   logic        clk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cmp_decision;
   logic [9:0]  trial_code;
   logic        sample_hold_n;
   logic        comparator_power;
   logic        internal_ref_select;
   logic        conversion_end_irq;
   logic [8:0]  analog_in_en;
   logic [8:0]  convert_sel;
   logic [2:0]  comparator_plus_en;
   logic        comparator_common_input;
   logic [9:0]  vin;
   logic [31:0] rd;
   logic        er;
   int          failures;
   int          cmp_count;
   int          seed;
   int          n;
   bit          got;

   sasq_top sasq_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_decision(cmp_decision), .trial_code(trial_code),
      .sample_hold_n(sample_hold_n), .comparator_power(comparator_power),
      .internal_ref_select(internal_ref_select), .conversion_end_irq(conversion_end_irq),
      .analog_in_en(analog_in_en), .convert_sel(convert_sel),
      .comparator_plus_en(comparator_plus_en),
      .comparator_common_input(comparator_common_input));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // The analog input is modelled as a code; the decision reaches the block one clock late.
   always @(posedge clk) begin
      cmp_decision <= (vin >= trial_code);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // Each transfer opens one edge after the call, so psel never toggles twice in a step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // A slave that never answers is left to the watchdog.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_irq(input int limit);
      n   = 0;
      got = 0;
      while (!got && n < limit) begin
         @(posedge clk);
         n++;
         got = (conversion_end_irq === 1'b1);
      end
   endtask : wait_irq

   function automatic logic [9:0] sar_model(input int v);
      int c;
      c = 0;
      for (int b = 9; b >= 0; b--) if (v >= (c | (1 << b))) c = c | (1 << b);
      return c[9:0];
   endfunction : sar_model

   task automatic check_result(input logic [9:0] v);
      logic [9:0] c;
      c = sar_model(int'(v));
      apb(1'b0, `SASQ_OFF_RES_FULL, 32'h0);
      check(rd, {22'h0, c});
      apb(1'b0, `SASQ_OFF_RES_HIGH, 32'h0);
      check(rd, {24'h0, c[9:2]});
      apb(1'b0, `SASQ_OFF_RES_LOW, 32'h0);
      check(rd, {24'h0, c[7:0]});
   endtask : check_result

   initial begin
      logic [7:0] cfg0, cfg1, dir2, dir7, c0, c1, c2;
      logic [8:0] ae;
      logic [3:0] ch;
      logic [9:0] vals [4];
      failures = 0;
      cmp_count = 0;
      seed = 32'h44990BAD;
      sys_rst = 1'b1;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0;
      vin = 10'h000;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 8; a <= 16; a += 4) begin
         apb(1'b0, a[11:0], 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b1, `SASQ_OFF_RES_FULL, 32'h0000FFFF);
      apb(1'b0, `SASQ_OFF_RES_FULL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h034, 32'h0);
      check({31'h0, er}, 32'h1);
      apb(1'b0, 12'h002, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      $display("test reset_values done");
      apb(1'b1, `SASQ_OFF_MODE, 32'h0000005A);
      apb(1'b0, `SASQ_OFF_MODE, 32'h0);
      check(rd, 32'h0000005A);
      repeat (2) @(posedge clk);
      check({internal_ref_select, comparator_power}, 32'h2);
      $display("test mode_register done");
      for (int i = 0; i < 8; i++) begin
         cfg0 = 8'($random(seed));
         cfg1 = 8'($random(seed));
         ch = 4'({$random(seed)} % 9);
         if (ch < 8) cfg0[ch[2:0]] = 1'b1;
         else cfg1[0] = 1'b1;
         dir2 = 8'($random(seed)) | cfg0;
         dir7 = 8'($random(seed)) | cfg1;
         c0 = (i == 0) ? 8'h98 : 8'($random(seed));
         c1 = 8'($random(seed));
         c2 = 8'($random(seed));
         apb(1'b1, `SASQ_OFF_PINCFG0, {24'h0, cfg0});
         apb(1'b1, `SASQ_OFF_PINCFG1, {24'h0, cfg1});
         apb(1'b1, `SASQ_OFF_PDIR2, {24'h0, dir2});
         apb(1'b1, `SASQ_OFF_PDIR7, {24'h0, dir7});
         apb(1'b1, `SASQ_OFF_CMPCTL0, {24'h0, c0});
         apb(1'b1, `SASQ_OFF_CMPCTL1, {24'h0, c1});
         apb(1'b1, `SASQ_OFF_CMPCTL2, {24'h0, c2});
         apb(1'b1, `SASQ_OFF_CHSEL, {28'h0, ch});
         repeat (3) @(posedge clk);
         ae = {cfg1[0] & dir7[0], cfg0 & dir2};
         check(analog_in_en, ae);
         check(convert_sel, ae & (9'h001 << ch));
         check(comparator_plus_en, {ae[3] & c2[7], ae[5] & c1[7], ae[4] & c0[7]});
         check(comparator_common_input, ae[6] & ((c0[4] & c0[3]) | (c1[4] & c1[3])
               | (c2[4] & c2[3])));
      end
      $display("test pin_functions done");
      apb(1'b1, `SASQ_OFF_PINCFG0, 32'h00000004);
      apb(1'b1, `SASQ_OFF_PDIR2, 32'h000000FF);
      apb(1'b1, `SASQ_OFF_CHSEL, 32'h00000002);
      apb(1'b1, `SASQ_OFF_MODE, 32'h0000009A);
      wait_irq(400);
      check({31'h0, got}, 32'h0);
      $display("test start_without_comparator done");
      apb(1'b1, `SASQ_OFF_MODE, 32'h0000001B);
      repeat (10) @(posedge clk);
      vin = 10'($random(seed));
      apb(1'b1, `SASQ_OFF_MODE, 32'h0000009B);
      n = 0;
      while (sample_hold_n !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (sample_hold_n === 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      check(n, 32'(`SASQ_SAMPLE_BASE) << 3);
      wait_irq(400);
      check({31'h0, got}, 32'h1);
      @(posedge clk);
      check(conversion_end_irq, 32'h0);
      check_result(vin);
      $display("test first_conversion done");
      vals = '{10'($random(seed)), 10'h000, 10'h3FF, 10'h200};
      for (int i = 0; i < 4; i++) begin
         vin = vals[i];
         wait_irq(400);
         check({31'h0, got}, 32'h1);
         check_result(vin);
      end
      $display("test back_to_back done");
      vin = 10'h155;
      wait_irq(400);
      repeat (100) @(posedge clk);
      apb(1'b1, `SASQ_OFF_CHSEL, 32'h00000002);
      wait_irq(400);
      check({30'h0, got, 1'b0} | 32'(n >= 224), 32'h3);
      check_result(vin);
      $display("test abort_restart done");
      apb(1'b1, `SASQ_OFF_MODE, 32'h0000001B);
      wait_irq(600);
      check({31'h0, got}, 32'h0);
      apb(1'b0, `SASQ_OFF_STATUS, 32'h0);
      check(rd, 32'h0);
      $display("test stop done");
      apb(1'b1, `SASQ_OFF_CHSEL, 32'h00000002);
      apb(1'b1, `SASQ_OFF_MODE, 32'h00000055);
      repeat (100) @(posedge clk);
      check(internal_ref_select, 32'h1);
      vin = 10'h2AA;
      apb(1'b1, `SASQ_OFF_MODE, 32'h000000D5);
      apb(1'b0, `SASQ_OFF_STATUS, 32'h0);
      check(rd, 32'h3);
      wait_irq(400);
      check({31'h0, got}, 32'h1);
      check_result(vin);
      $display("test restart done");
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule : sasq_top_tb_top
